// File: rtl/llr_pkg.sv
// Package for the link layer register bank and front-end control
// Function
// RL1: Front-end outputs driven only when master enabled
// RL2: Tx amp enable active during transmit, leads
// RL3: Rx amp enable active while receiving only
// RL4: Chip enable active when tx or rx
// RL5: Bit 1 sets chip enable polarity
// RL6: Bit 2 sets tx amp polarity
// RL7: Bit 3 sets rx amp polarity
// RL8: Command register accepts eight-bit instruction code
// RL9: Feature bit 0 enables address privacy
// RL10: Feature bit 1 enables long packets
// RL11: Table not full: hardware responds itself
// RL12: Table full: firmware list also compared
// RL13: Sent status: index write sets, read flags
// RL14: Ack status read returns awaiting flags
// RL15: Firmware clears ack flag by index
// RL16: Slot timer holds next slot, 625 us
// RL17: Firmware programs timer 1.25 ms ahead
// RL18: Four parameter memories, 16-bit, multi-link valid
// RL19: Static parameters at word offsets 00-30
// RL20: Running state at offsets 38 to 48
// RL21: Descriptor bits 1:0 give PDU kind
// RL22: Payload length bits 9:2, upper need long
// RL23: Master disabled holds outputs inactive
package llr_pkg;
	localparam logic [11:0] LLR_CMD_OFF = 12'h000;
	localparam logic [11:0] LLR_FEAT_OFF = 12'h004;
	localparam logic [11:0] LLR_SENT_OFF = 12'h008;
	localparam logic [11:0] LLR_ACK_OFF = 12'h00C;
	localparam logic [11:0] LLR_SLOT_OFF = 12'h010;
	localparam logic [11:0] LLR_DESC_OFF = 12'h014;
	localparam logic [11:0] LLR_FE_OFF = 12'h018;
	localparam logic [11:0] LLR_STAT_OFF = 12'h01C;
	localparam logic [11:0] LLR_MEM_OFF = 12'h400;
	localparam int LLR_MEM_CONN_BIT = 8;
	localparam int LLR_MEM_WORDS = 64;
	localparam int LLR_FE_EN_BIT = 0;
	localparam int LLR_FE_CE_POL_BIT = 1;
	localparam int LLR_FE_TX_POL_BIT = 2;
	localparam int LLR_FE_RX_POL_BIT = 3;
	localparam int LLR_FEAT_PRIV_BIT = 0;
	localparam int LLR_FEAT_LONG_BIT = 1;
	localparam int LLR_FEAT_FULL_BIT = 4;
	localparam int LLR_FEAT_MULTI_BIT = 5;
	localparam int LLR_UPD_BIT = 7;
	localparam logic [5:0] LLR_FEAT_MASK = 6'h33;
	localparam logic [9:0] LLR_DESC_RESET = 10'h000;
	localparam logic [3:0] LLR_FE_RESET = 4'h0;
	localparam int LLR_SLOT_US = 625;
	localparam int LLR_SLOT_LEAD_US = 1250;
	localparam int LLR_CLK_MHZ = 10;
	localparam int LLR_PA_LEAD_NS = 1000;
	localparam int LLR_CLK_NS = 100;
	localparam int LLR_PA_LEAD_CYC = (LLR_PA_LEAD_NS + LLR_CLK_NS - 1) / LLR_CLK_NS;
	localparam logic [1:0] LLR_PDU_RSVD = 2'h0;
	localparam logic [1:0] LLR_PDU_CONT = 2'h1;
	localparam logic [1:0] LLR_PDU_START = 2'h2;
	localparam logic [1:0] LLR_PDU_CTRL = 2'h3;
endpackage

// File: rtl/llr_regs.sv
// Link layer register bank with APB slave and front-end control outputs
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module llr_regs
	import llr_pkg::*;
#(
	parameter int NUM_BUF = 4,
	parameter int NUM_CONN = 4
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_resetn,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Radio core status
	input wire logic i_tx_request,
	input wire logic i_rx_active,
	input wire logic [NUM_BUF-1:0] i_buf_transmitted,
	input wire logic [NUM_BUF-1:0] i_buf_acked,
	input wire logic i_peer_unresolved,
	// Radio core controls
	output logic o_tx_start,
	output logic [7:0] o_command,
	output logic o_command_valid,
	output logic o_address_privacy_enable,
	output logic o_long_packet_enable,
	output logic o_multi_link_mode,
	output logic o_hw_respond,
	output logic o_fw_lookup_request,
	output logic [15:0] o_next_event_slot,
	output logic [1:0] o_pdu_kind,
	output logic [7:0] o_payload_length,
	// Front-end pins
	output logic o_tx_amp_en,
	output logic o_rx_amp_en,
	output logic o_front_end_power
);
	logic [3:0] fe_reg;
	logic [5:0] feat_reg;
	logic [NUM_BUF-1:0] sent_reg;
	logic [NUM_BUF-1:0] ack_reg;
	logic [15:0] slot_reg;
	logic [9:0] desc_reg;
	logic [7:0] cmd_reg;
	logic cmd_valid_reg;
	logic [15:0] mem [NUM_CONN*LLR_MEM_WORDS];
	logic [3:0] lead_reg;
	logic tx_on_reg;
	logic tx_start_reg;
	logic [31:0] rdata_next;
	logic err_next;
	logic wr_en;
	logic rd_en;
	logic mem_hit;
	logic [7:0] mem_idx;
	logic fe_wr;
	logic feat_wr;
	logic cmd_wr;
	logic sent_wr;
	logic ack_wr;
	logic slot_wr;
	logic desc_wr;
	logic mem_wr;
	logic [NUM_BUF-1:0] buf_sel;

	function automatic logic [NUM_BUF-1:0] llr_onehot(input logic [3:0] idx);
		logic [NUM_BUF-1:0] v;
		v = '0;
		for (int k = 0; k < NUM_BUF; k++) begin
			if (idx == 4'(k)) begin
				v[k] = 1'b1;
			end
		end
		return v;
	endfunction

	// Write lands at the access edge where ready is high
	assign wr_en = i_psel && i_penable && i_pwrite && o_pready;
	// Read data is captured in the setup cycle
	assign rd_en = i_psel && !i_penable && !i_pwrite;
	assign mem_hit = (i_paddr >= LLR_MEM_OFF) && (i_paddr[11:10] == 2'h1);
	assign mem_idx = i_paddr[9:2];
	// Per-register write strobes
	assign fe_wr = wr_en && i_paddr == LLR_FE_OFF;
	assign feat_wr = wr_en && i_paddr == LLR_FEAT_OFF;
	assign cmd_wr = wr_en && i_paddr == LLR_CMD_OFF;
	assign sent_wr = wr_en && i_paddr == LLR_SENT_OFF && i_pwdata[LLR_UPD_BIT];
	assign ack_wr = wr_en && i_paddr == LLR_ACK_OFF && i_pwdata[LLR_UPD_BIT];
	assign slot_wr = wr_en && i_paddr == LLR_SLOT_OFF;
	assign desc_wr = wr_en && i_paddr == LLR_DESC_OFF;
	assign mem_wr = wr_en && mem_hit;
	assign buf_sel = llr_onehot(i_pwdata[3:0]);

	// Zero-wait APB answer
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			o_pready <= 1'b0;
		end else begin
			o_pready <= i_psel && !i_penable;
		end
	end

	// Front-end control register
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			fe_reg <= LLR_FE_RESET;
		end else if (fe_wr) begin
			fe_reg <= i_pwdata[3:0]; // [RL5] [RL6] [RL7]
		end
	end

	// Feature control register
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			feat_reg <= '0;
		end else if (feat_wr) begin
			feat_reg <= i_pwdata[5:0] & LLR_FEAT_MASK; // [RL9] [RL10]
		end
	end

	// Command strobe, one cycle per accepted write
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			cmd_valid_reg <= 1'b0;
		end else begin
			cmd_valid_reg <= cmd_wr; // [RL8]
		end
	end

	// Command code, held until the next write
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			cmd_reg <= 8'h00;
		end else if (cmd_wr) begin
			cmd_reg <= i_pwdata[7:0]; // [RL8]
		end
	end

	// Sent flags: firmware sets by index, hardware clears on transmit
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			sent_reg <= '0;
		end else begin
			sent_reg <= (sent_reg & ~i_buf_transmitted) | (sent_wr ? buf_sel : '0); // [RL13]
		end
	end

	// Ack flags: hardware sets, firmware clears, set wins
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			ack_reg <= '0;
		end else begin
			ack_reg <= (ack_reg & ~(ack_wr ? buf_sel : '0)) | (i_buf_transmitted & ~i_buf_acked); // [RL14] [RL15]
		end
	end

	// Next event slot
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			slot_reg <= 16'h0000;
		end else if (slot_wr) begin
			slot_reg <= i_pwdata[15:0]; // [RL16]
		end
	end

	// Packet descriptor
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			desc_reg <= LLR_DESC_RESET;
		end else if (desc_wr) begin
			desc_reg <= i_pwdata[9:0]; // [RL21] [RL22]
		end
	end

	// Per-link parameter memory, 16-bit words
	always_ff @(posedge i_core_clk) begin
		if (mem_wr) begin
			mem[mem_idx] <= i_pwdata[15:0]; // [RL18] [RL19] [RL20]
		end
	end

	// Read mux
	always_comb begin
		rdata_next = 32'h0000_0000;
		err_next = 1'b0;
		if (mem_hit) begin
			rdata_next = {16'h0000, feat_reg[LLR_FEAT_MULTI_BIT] ? mem[mem_idx] : 16'h0000}; // [RL18]
		end else begin
			case (i_paddr)
				LLR_CMD_OFF: rdata_next = 32'h0000_0000;
				LLR_FEAT_OFF: rdata_next = {26'h0, feat_reg};
				LLR_SENT_OFF: rdata_next = {{(32-NUM_BUF){1'b0}}, sent_reg}; // [RL13]
				LLR_ACK_OFF: rdata_next = {{(32-NUM_BUF){1'b0}}, ack_reg}; // [RL14]
				LLR_SLOT_OFF: rdata_next = {16'h0000, slot_reg};
				LLR_DESC_OFF: rdata_next = {22'h0, desc_reg};
				LLR_FE_OFF: rdata_next = {28'h0, fe_reg};
				LLR_STAT_OFF: rdata_next = {29'h0, tx_on_reg, i_rx_active, i_tx_request};
				default: err_next = 1'b1;
			endcase
		end
	end

	// Read data, shown in the access cycle only
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			o_prdata <= 32'h0000_0000;
		end else begin
			o_prdata <= rd_en ? rdata_next : 32'h0000_0000;
		end
	end

	// Error answer for unmapped addresses
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			o_pslverr <= 1'b0;
		end else begin
			o_pslverr <= i_psel && !i_penable && err_next;
		end
	end

	// Amplifier ramp lead counter before transmit start
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			lead_reg <= 4'h0;
		end else if (!i_tx_request) begin
			lead_reg <= 4'h0;
		end else if (!tx_on_reg && lead_reg != 4'(LLR_PA_LEAD_CYC)) begin
			lead_reg <= lead_reg + 4'h1;
		end
	end

	// Transmit on once the lead has run out
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			tx_on_reg <= 1'b0;
		end else if (!i_tx_request) begin
			tx_on_reg <= 1'b0;
		end else if (lead_reg == 4'(LLR_PA_LEAD_CYC)) begin
			tx_on_reg <= 1'b1; // [RL2]
		end
	end

	// One-cycle start strobe when transmit turns on
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			tx_start_reg <= 1'b0;
		end else begin
			tx_start_reg <= i_tx_request && !tx_on_reg && lead_reg == 4'(LLR_PA_LEAD_CYC); // [RL2]
		end
	end

	// Transmit amplifier pin
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			o_tx_amp_en <= 1'b0;
		end else begin
			o_tx_amp_en <= (fe_reg[LLR_FE_EN_BIT] && i_tx_request) ^ fe_reg[LLR_FE_TX_POL_BIT]; // [RL1] [RL2] [RL6] [RL23]
		end
	end

	// Receive amplifier pin, off while transmitting
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			o_rx_amp_en <= 1'b0;
		end else begin
			o_rx_amp_en <= (fe_reg[LLR_FE_EN_BIT] && i_rx_active && !i_tx_request) ^ fe_reg[LLR_FE_RX_POL_BIT]; // [RL3] [RL7] [RL23]
		end
	end

	// Front-end power pin
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			o_front_end_power <= 1'b0;
		end else begin
			o_front_end_power <= (fe_reg[LLR_FE_EN_BIT] && (i_tx_request || i_rx_active))
				^ fe_reg[LLR_FE_CE_POL_BIT]; // [RL4] [RL5] [RL23]
		end
	end

	// Transmit start strobe
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			o_tx_start <= 1'b0;
		end else begin
			o_tx_start <= tx_start_reg; // [RL2]
		end
	end

	// Command code to the core
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			o_command <= 8'h00;
		end else begin
			o_command <= cmd_reg; // [RL8]
		end
	end

	// Command strobe to the core
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			o_command_valid <= 1'b0;
		end else begin
			o_command_valid <= cmd_valid_reg; // [RL8]
		end
	end

	// Feature levels
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			o_address_privacy_enable <= 1'b0;
		end else begin
			o_address_privacy_enable <= feat_reg[LLR_FEAT_PRIV_BIT]; // [RL9]
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			o_long_packet_enable <= 1'b0;
		end else begin
			o_long_packet_enable <= feat_reg[LLR_FEAT_LONG_BIT]; // [RL10]
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			o_multi_link_mode <= 1'b0;
		end else begin
			o_multi_link_mode <= feat_reg[LLR_FEAT_MULTI_BIT]; // [RL18]
		end
	end

	// Address resolution requests
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			o_hw_respond <= 1'b0;
		end else begin
			o_hw_respond <= feat_reg[LLR_FEAT_PRIV_BIT] && !feat_reg[LLR_FEAT_FULL_BIT]
				&& i_peer_unresolved; // [RL11]
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			o_fw_lookup_request <= 1'b0;
		end else begin
			o_fw_lookup_request <= feat_reg[LLR_FEAT_PRIV_BIT] && feat_reg[LLR_FEAT_FULL_BIT]
				&& i_peer_unresolved; // [RL12]
		end
	end

	// Slot and descriptor fields
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			o_next_event_slot <= 16'h0000;
		end else begin
			o_next_event_slot <= slot_reg; // [RL16]
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			o_pdu_kind <= LLR_PDU_RSVD;
		end else begin
			o_pdu_kind <= desc_reg[1:0]; // [RL21]
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			o_payload_length <= 8'h00;
		end else begin
			o_payload_length <= feat_reg[LLR_FEAT_LONG_BIT] ? desc_reg[9:2] : {3'h0, desc_reg[6:2]}; // [RL22]
		end
	end
endmodule
`default_nettype wire

// File: verif/llr_regs_asserts.sv
// Assertion checker for the link layer register bank
`timescale 1ns/1ns
`default_nettype none
module llr_regs_chk
	import llr_pkg::*;
(
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_resetn,
	// APB
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic o_pready,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	// Core side
	input wire logic i_tx_request,
	input wire logic i_rx_active,
	input wire logic o_tx_start,
	input wire logic o_command_valid,
	input wire logic [7:0] o_command,
	input wire logic o_address_privacy_enable,
	input wire logic o_long_packet_enable,
	input wire logic [15:0] o_next_event_slot,
	input wire logic [1:0] o_pdu_kind,
	input wire logic [7:0] o_payload_length,
	// Front-end pins
	input wire logic o_tx_amp_en,
	input wire logic o_rx_amp_en,
	input wire logic o_front_end_power
);
	logic [3:0] fe_reg;
	logic [31:0] wd_reg;
	logic wr;
	assign wr = i_psel & i_penable & o_pready & i_pwrite;
	// Shadow of front-end setting and last write data
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) fe_reg <= 4'h0;
		else if (wr && i_paddr == LLR_FE_OFF) fe_reg <= i_pwdata[3:0];
	end
	always_ff @(posedge i_core_clk) begin
		if (wr) wd_reg <= i_pwdata;
	end
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);
	chk_tx_amp_pin: assert property (o_tx_amp_en == ($past(fe_reg[0] & i_tx_request) ^ $past(fe_reg[2])))
		else $error("tx amp pin wrong");
	chk_rx_amp_pin: assert property (o_rx_amp_en == ($past(fe_reg[0] & i_rx_active & !i_tx_request) ^ $past(fe_reg[3])))
		else $error("rx amp pin wrong");
	chk_power_pin: assert property (o_front_end_power == ($past(fe_reg[0] & (i_tx_request | i_rx_active)) ^ $past(fe_reg[1])))
		else $error("power pin wrong");
	chk_tx_lead: assert property (o_tx_start |-> i_tx_request && $past(i_tx_request, 10))
		else $error("tx start without lead");
	chk_cmd_pulse: assert property (wr && i_paddr == LLR_CMD_OFF |-> ##[1:3] (o_command_valid && o_command == wd_reg[7:0]))
		else $error("command not issued");
	chk_feat_out: assert property (wr && i_paddr == LLR_FEAT_OFF |-> ##[1:2]
		(o_address_privacy_enable == wd_reg[0] && o_long_packet_enable == wd_reg[1]))
		else $error("feature outputs wrong");
	chk_slot_out: assert property (wr && i_paddr == LLR_SLOT_OFF |-> ##[1:2] o_next_event_slot == wd_reg[15:0])
		else $error("slot output wrong");
	chk_desc_out: assert property (wr && i_paddr == LLR_DESC_OFF |-> ##[1:2] (o_pdu_kind == wd_reg[1:0] &&
		o_payload_length == (o_long_packet_enable ? wd_reg[9:2] : {3'h0, wd_reg[6:2]})))
		else $error("descriptor outputs wrong");
endmodule
bind llr_regs llr_regs_chk u_chk (.*);
`default_nettype wire

// File: verif/llr_fe_model.sv
// Behavioural external amplifier front end
`timescale 1ns/1ns
`default_nettype none
module llr_fe_model (
	input wire logic [3:0] i_pol,
	input wire logic i_tx_amp_en, i_rx_amp_en, i_front_end_power,
	output logic [2:0] o_on
);
	// Active states {awake, lna, pa}
	assign o_on = {i_front_end_power ^ i_pol[1], i_rx_amp_en ^ i_pol[3], i_tx_amp_en ^ i_pol[2]};
endmodule
`default_nettype wire

// File: verif/tb_top.sv
// Self-checking testbench for the link layer register bank
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import llr_pkg::*;
();
	logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, tx = 1'b0, rx = 1'b0, peer = 1'b0;
	logic [11:0] addr = 12'h000;
	logic [31:0] wdat = 32'h0, lv = 32'h89EB40CB, got, sent_m = 32'h0, ack_m = 32'h0, rdat;
	logic [3:0] trans = 4'h0, fe_m = 4'h0, acked = 4'h0;
	logic rdy, err, gerr, txa, rxa, pwp, hwr, fwl, mlm;
	logic [2:0] on;
	int bad_count = 0, total_checks = 0, cyc = 0;
	always #50 clk = ~clk;
	llr_regs dut (.i_core_clk(clk), .i_resetn(rstn), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
		.i_paddr(addr), .i_pwdata(wdat), .o_prdata(rdat), .o_pready(rdy), .o_pslverr(err),
		.i_tx_request(tx), .i_rx_active(rx), .i_buf_transmitted(trans), .i_buf_acked(acked),
		.i_peer_unresolved(peer), .o_tx_start(), .o_command(), .o_command_valid(),
		.o_address_privacy_enable(), .o_long_packet_enable(), .o_multi_link_mode(mlm), .o_hw_respond(hwr),
		.o_fw_lookup_request(fwl), .o_next_event_slot(), .o_pdu_kind(), .o_payload_length(),
		.o_tx_amp_en(txa), .o_rx_amp_en(rxa), .o_front_end_power(pwp));
	llr_fe_model fem (.i_pol(fe_m), .i_tx_amp_en(txa), .i_rx_amp_en(rxa), .i_front_end_power(pwp), .o_on(on));
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwr <= w;
		addr <= a;
		wdat <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (rdy !== 1'b1);
		got = rdat;
		gerr = err;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check(got, e);
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc > 5000) begin
			bad_count++;
			end_sim();
		end
	end
	initial begin
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		for (int a = 4; a < 32; a += 4) rd(12'(a), 32'h0);
		apb(1'b0, 12'h020, 32'h0);
		check({31'h0, gerr}, 32'h1);
		repeat (8) begin
			lv = lfsr(lv);
			apb(1'b1, LLR_CMD_OFF, lv);
			rd(LLR_CMD_OFF, 32'h0);
			peer <= lv[2];
			apb(1'b1, LLR_FEAT_OFF, lv);
			rd(LLR_FEAT_OFF, lv & {26'h0, LLR_FEAT_MASK});
			check({29'h0, mlm, fwl, hwr}, {29'h0, lv[5], lv[0] & lv[4] & lv[2], lv[0] & !lv[4] & lv[2]});
			apb(1'b1, LLR_SLOT_OFF, lv);
			rd(LLR_SLOT_OFF, {16'h0, lv[15:0]});
			apb(1'b1, LLR_DESC_OFF, lv);
			rd(LLR_DESC_OFF, {22'h0, lv[9:0]});
		end
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, LLR_SENT_OFF, 32'h80 | 32'(i));
			sent_m[i] = 1'b1;
			rd(LLR_SENT_OFF, sent_m);
			trans <= 4'h1 << i;
			@(posedge clk);
			trans <= 4'h0;
			@(posedge clk);
			sent_m[i] = 1'b0;
			ack_m[i] = 1'b1;
			rd(LLR_SENT_OFF, sent_m);
			rd(LLR_ACK_OFF, ack_m);
			apb(1'b1, LLR_ACK_OFF, 32'h80 | 32'(i));
			ack_m[i] = 1'b0;
			rd(LLR_ACK_OFF, ack_m);
		end
		apb(1'b1, LLR_SENT_OFF, 32'h80);
		trans <= 4'h1;
		acked <= 4'h1;
		@(posedge clk);
		trans <= 4'h0;
		acked <= 4'h0;
		@(posedge clk);
		rd(LLR_SENT_OFF, 32'h0);
		rd(LLR_ACK_OFF, 32'h0);
		for (int n = 0; n < 4; n++) begin
			lv = lfsr(lv);
			apb(1'b1, LLR_FEAT_OFF, 32'h20);
			apb(1'b1, 12'(32'h430 + n * 32'h100 + (n % 2) * 32'h18), lv);
			rd(12'(32'h430 + n * 32'h100 + (n % 2) * 32'h18), {16'h0, lv[15:0]});
			apb(1'b1, LLR_FEAT_OFF, 32'h0);
			rd(12'(32'h430 + n * 32'h100 + (n % 2) * 32'h18), 32'h0);
		end
		for (int f = 0; f < 16; f++) begin
			apb(1'b1, LLR_FE_OFF, 32'(f));
			fe_m = 4'(f);
			for (int m = 0; m < 4; m++) begin
				tx <= m[0];
				rx <= m[1];
				repeat (14) @(posedge clk);
				check({29'h0, on}, {29'h0, f[0] & (m[0] | m[1]), f[0] & m[1] & !m[0], f[0] & m[0]});
			end
		end
		end_sim();
	end
endmodule
`default_nettype wire
